/* File: led_power_down.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "led_pd_cfg.svh"

module led_power_down
	import led_pd_pkg::*;
#(
	parameter int CHANNELS = 36
)
(
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rst_n,
	// register port
	input  wire logic [7:0]          addr,
	input  wire logic [7:0]          wdata,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [7:0]          rdata,
	// pins and channels
	input  wire logic                power_down_pin_n,
	input  wire logic [CHANNELS-1:0] chan_request,
	output logic      [CHANNELS-1:0] chan_drive,
	output logic                     chan_active
);

	// ****************************************
	// register state
	// ****************************************
	byte_t          ctrl_q, ctrl_d;
	logic     [5:0] gidx_q, gidx_d;
	byte_t          rdata_q, rdata_d;
	logic     [7:0] gamma_code;
	byte_t          status;
	logic           hit_ctrl;
	logic           hit_gidx;
	pd_mode_e       mode;

	// ****************************************
	// gamma lookup
	// ****************************************
	// fixed curve; software picks the index, reads the code back
	gamma_rom u_gamma
	(
		.index (gidx_q),
		.code  (gamma_code)
	);

	// ****************************************
	// register port
	// ****************************************
	// address decode for the writable registers
	always_comb
	begin
		hit_ctrl = wr_en && (addr == `PD_CTRL_OFFSET);
		hit_gidx = wr_en && (addr == `GAMMA_IDX_OFFSET);
	end

	// register writes; nothing here depends on mode
	always_comb
	begin
		ctrl_d = ctrl_q;
		gidx_d = gidx_q;
		if (hit_ctrl)
		begin
			ctrl_d = wdata; // all eight bits kept
		end
		if (hit_gidx)
		begin
			gidx_d = wdata[5:0]; // upper bits dropped
		end
	end

	// ****************************************
	// status byte
	// ****************************************
	// one-hot mode report, soft shutdown first
	always_comb
	begin
		status                    = 8'h00;
		status[`STAT_SOFT_PD_POS] = (mode == MODE_SOFT_PD);
		status[`STAT_HARD_PD_POS] = (mode == MODE_HARD_PD);
		status[`STAT_RUN_POS]     = (mode == MODE_RUN);
	end

	// read mux, unmapped or idle reads zero
	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_en)
		begin
			case (addr)
				`PD_CTRL_OFFSET:
				begin
					rdata_d = ctrl_q;
				end
				`GAMMA_IDX_OFFSET:
				begin
					rdata_d = {2'h0, gidx_q};
				end
				`GAMMA_CODE_OFFSET:
				begin
					rdata_d = gamma_code;
				end
				`STATUS_OFFSET:
				begin
					rdata_d = status;
				end
				default:
				begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	// register file and read data flops
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ctrl_q  <= `PD_CTRL_RESET;
			gidx_q  <= 6'(`GAMMA_IDX_RESET);
			rdata_q <= 8'h00;
		end
		else
		begin
			ctrl_q  <= ctrl_d;
			gidx_q  <= gidx_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// shutdown decision
	// ****************************************
	// pin low wins over the soft bit
	always_comb
	begin
		if (!power_down_pin_n)
		begin
			mode = MODE_HARD_PD;
		end
		else if (!ctrl_q[`SOFT_PD_BIT_POS])
		begin
			mode = MODE_SOFT_PD;
		end
		else
		begin
			mode = MODE_RUN;
		end
	end

	// ****************************************
	// channel gating
	// ****************************************
	logic                      active_q, active_d;
	logic [CHANNELS-1:0]       drive_q, drive_d;
	wire  logic [CHANNELS-1:0] gated;

	// one gate per channel; no chan_request bit can bypass it
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++)
		begin : g_gate
			assign gated[ch] = (mode == MODE_RUN) & chan_request[ch];
		end
	endgenerate

	// run only with pin high and soft bit set
	always_comb
	begin
		active_d = (mode == MODE_RUN);
		drive_d  = gated;
	end

	// registered so nothing glitches onto the pins
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			drive_q  <= '0;
			active_q <= 1'b0;
		end
		else
		begin
			drive_q  <= drive_d;
			active_q <= active_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// every output straight from its flop
	assign rdata       = rdata_q;
	assign chan_drive  = drive_q;
	assign chan_active = active_q;

endmodule

`default_nettype wire

/* File: led_pd_cfg.svh */
`ifndef LED_PD_CFG_SVH
`define LED_PD_CFG_SVH

// ****************************************
// register map and fields
// ****************************************
`define PD_CTRL_OFFSET     8'h00
`define GAMMA_IDX_OFFSET   8'h01
`define GAMMA_CODE_OFFSET  8'h02
`define STATUS_OFFSET      8'h03
`define SOFT_PD_BIT_POS    0
`define PD_CTRL_RESET      8'h00
`define GAMMA_IDX_RESET    8'h00

// ****************************************
// status fields
// ****************************************
`define STAT_SOFT_PD_POS   0
`define STAT_HARD_PD_POS   1
`define STAT_RUN_POS       2

`endif

/* File: led_pd_pkg.sv */
package led_pd_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {MODE_RUN, MODE_SOFT_PD, MODE_HARD_PD} pd_mode_e;
endpackage

/* File: gamma_rom.sv */
`timescale 1ns/10ps
`default_nettype none

module gamma_rom
	import led_pd_pkg::*;
(
	// lookup
	input  wire logic [5:0] index,
	output logic      [7:0] code
);

	// 64-step monotonic duty curve, 0 to full scale
	localparam logic [511:0] TABLE = {
		8'hFF, 8'hFB, 8'hF4, 8'hED, 8'hE6, 8'hDF, 8'hD8, 8'hD1,
		8'hCA, 8'hC3, 8'hBC, 8'hB6, 8'hB0, 8'hAA, 8'hA4, 8'h9E,
		8'h98, 8'h92, 8'h8C, 8'h86, 8'h81, 8'h7C, 8'h77, 8'h72,
		8'h6D, 8'h68, 8'h63, 8'h5E, 8'h59, 8'h55, 8'h51, 8'h4D,
		8'h49, 8'h45, 8'h41, 8'h3D, 8'h39, 8'h35, 8'h32, 8'h2F,
		8'h2C, 8'h29, 8'h26, 8'h23, 8'h20, 8'h1D, 8'h1A, 8'h18,
		8'h16, 8'h14, 8'h12, 8'h10, 8'h0E, 8'h0C, 8'h0A, 8'h08,
		8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00
	};

	// entry select
	always_comb
	begin
		code = TABLE[{index, 3'h0} +: 8];
	end

endmodule

`default_nettype wire

/* File: led_pd_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module led_pd_chk
	import led_pd_pkg::*;
#(parameter int CHANNELS = 36)
(
	// watched ports
	input wire logic                clock,
	input wire logic                rst_n,
	input wire logic [7:0]          addr,
	input wire logic [7:0]          wdata,
	input wire logic                wr_en,
	input wire logic                rd_en,
	input wire logic [7:0]          rdata,
	input wire logic                power_down_pin_n,
	input wire logic [CHANNELS-1:0] chan_request,
	input wire logic [CHANNELS-1:0] chan_drive,
	input wire logic                chan_active
);
	byte_t ctrl_d;
	byte_t ctrl_q;
	// shadow of control byte
	always_comb ctrl_d = (wr_en && addr == 8'h00) ? wdata : ctrl_q;
	always_ff @(posedge clock) ctrl_q <= rst_n ? ctrl_d : 8'h00;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_pin; !power_down_pin_n |=> !chan_active && chan_drive == '0; endproperty
	a_pin: assert property (p_pin) else $error("pin");
	property p_run; chan_active == ($past(power_down_pin_n) && $past(ctrl_q[0])); endproperty
	a_run: assert property (p_run) else $error("run");
	property p_gate; chan_drive == ($past(chan_request) & {CHANNELS{chan_active}}); endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_soft; wr_en && addr == 8'h00 && !wdata[0] |-> ##2 !chan_active; endproperty
	a_soft: assert property (p_soft) else $error("soft");
	property p_rst; $rose(rst_n) |-> !chan_active [*2]; endproperty
	a_rst: assert property (p_rst) else $error("rst");
	property p_keep; rd_en && addr == 8'h00 |=> rdata == $past(ctrl_q); endproperty
	a_keep: assert property (p_keep) else $error("keep");
	c_run: cover property (chan_active);
	c_hard: cover property (chan_active ##1 !power_down_pin_n);
	c_read: cover property (rd_en && addr == 8'h00);
endmodule
bind led_power_down led_pd_chk #(.CHANNELS(CHANNELS)) chk (.*);
`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model
	import led_pd_pkg::*;
(
	// register port
	input  wire logic       clock,
	input  wire logic [7:0] rdata,
	output var logic  [7:0] addr,
	output var logic  [7:0] wdata,
	output var logic        wr_en,
	output var logic        rd_en
);
	// idle bus
	initial
	begin
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	task automatic wr(input byte_t a, d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input byte_t a, output byte_t d);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		// read data stand only in this cycle
		@(negedge clock);
		d = rdata;
	endtask
	// step index to duty code
	task automatic gamma(input byte_t i, output byte_t c);
		wr(8'h01, i);
		rd(8'h02, c);
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        pin_n = 1'b1;
	logic [35:0] req = '0;
	logic [35:0] drive;
	logic [7:0]  addr, wdata, rdata, v;
	logic        wr_en, rd_en, active;
	int          bad_count = 0, n_checks = 0, cyc = 0;
	always #5 clock = ~clock;
	host_model h (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en));
	led_power_down dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .power_down_pin_n(pin_n),
		.chan_request(req), .chan_drive(drive), .chan_active(active));
	task chk(input logic [36:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %0t mismatch", $time);
		end
	endtask
	task print_verdict;
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 500)
		begin
			bad_count++;
			print_verdict;
		end
	end
	task t_soft;
		h.rd(8'h00, v);
		chk(v, 8'h00);
		h.rd(8'h03, v);
		chk(v, 8'h01);
		@(posedge clock) req <= 36'hF_0F0F_0F0F;
		h.wr(8'h00, 8'h01);
		repeat (3) @(posedge clock);
		chk({drive, active}, {36'hF_0F0F_0F0F, 1'b1});
		h.rd(8'h03, v);
		chk(v, 8'h04);
		h.wr(8'h00, 8'hFE);
		repeat (3) @(posedge clock);
		chk({drive, active}, 0);
		h.rd(8'h03, v);
		chk(v, 8'h01);
		h.rd(8'h00, v);
		chk(v, 8'hFE);
	endtask
	task t_hard;
		h.wr(8'h00, 8'hA5);
		@(posedge clock) pin_n <= 1'b0;
		repeat (3) @(posedge clock);
		chk({drive, active}, 0);
		h.rd(8'h03, v);
		chk(v, 8'h02);
		h.rd(8'h00, v);
		chk(v, 8'hA5);
		@(posedge clock) pin_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk({drive, active}, {req, 1'b1});
		h.rd(8'h07, v);
		chk(v, 8'h00);
	endtask
	initial
	begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_soft;
		t_hard;
		h.gamma(8'h3F, v);
		chk(v, 8'hFF);
		h.gamma(8'h00, v);
		chk(v, 8'h00);
		h.gamma(8'h09, v);
		chk(v, 8'h0A);
		h.gamma(8'h1F, v);
		chk(v, 8'h49);
		h.gamma(8'h2D, v);
		chk(v, 8'h8C);
		print_verdict;
	end
endmodule
`default_nettype wire
